// ==== dv/acs_partner.sv ====
// far-side model: converter cores and dma controller
`timescale 1ns/100ps
module acs_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // converter cores
    input wire logic [2:0] convStart,
    input wire logic [2:0][3:0] convChannel,
    output wire logic [2:0] convDone,
    output wire logic [2:0][11:0] convResult,
    // dma controller and converter busy
    input wire logic [2:0] dmaReq,
    output wire logic [2:0] dmaDone,
    output wire logic [2:0] busy
);
    for (genvar u = 0; u < 3; u++)
    begin : g_unit
        int cw;
        int dw;
        logic cd;
        logic dd;
        always @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                cw <= 0;
                dw <= 0;
                cd <= 1'b0;
                dd <= 1'b0;
            end
            else
            begin
                cd <= cw == 1;
                cw <= convStart[u] ? 1 + $urandom % 4 : (cw > 0 ? cw - 1 : 0);
                // one done per request, random delay
                dd <= dw == 1;
                dw <= (dmaReq[u] && dw == 0 && !dd) ? 1 + $urandom % 4 : (dw > 0 ? dw - 1 : 0);
            end
        end
        // idle result lines show inverse, not last value
        assign convResult[u] = cd ? {3{convChannel[u]}} : ~{3{convChannel[u]}};
        assign convDone[u] = cd;
        assign dmaDone[u] = dd;
        assign busy[u] = cw != 0 || cd;
    end
endmodule

// ==== dv/tb_top.sv ====
// bench for the three-unit conversion sequencer
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] trig = 6'h0;
    logic hreadyout, hresp, rdPend;
    logic [31:0] hrdata;
    logic [2:0] convStart, convDone, dmaReq, dmaDone, irq, busy;
    logic [2:0][3:0] convChannel;
    logic [2:0][11:0] convResult;
    int n_mismatch = 0;
    int n_tests = 0;
    int since, lastGap;
    logic [31:0] expRd[$];
    logic [5:0] expCh[$];
    always #2.5 clk = ~clk;
    acs_top dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .extTrig(trig[0]),
        .timerTrig(trig[3:1]), .pulseGenTrig(trig[5:4]), .convStart(convStart),
        .convChannel(convChannel), .convDone(convDone), .convResult(convResult),
        .dmaReq(dmaReq), .dmaDone(dmaDone), .irq(irq));
    acs_partner far (.clk(clk), .rst_b(rst_b), .convStart(convStart),
        .convChannel(convChannel), .convDone(convDone), .convResult(convResult),
        .dmaReq(dmaReq), .dmaDone(dmaDone), .busy(busy));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] ra(input int u, input logic [7:0] off);
        return acs_pkg::ACS_BASE_ADDR + acs_pkg::ACS_UNIT_STRIDE * u[31:0] + {24'h0, off};
    endfunction
    // bounded wait; a counted timeout ends the run
    task automatic waitFor(input int lim, input bit idle);
        int k;
        int q;
        q = 0;
        for (k = 0; k < lim && q < (idle ? 40 : 1); k++)
        begin
            @(posedge clk);
            q = idle ? ((busy | dmaReq | convStart) === 3'h0 ? q + 1 : 0) : hreadyout === 1'b1;
        end
        if (q < (idle ? 40 : 1))
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        waitFor(20, 0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitFor(20, 0);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expRd.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask
    always @(posedge clk)
    begin
        if (hreadyout === 1'b1 && rdPend === 1'b1)
            chk("hrdata", hrdata, expRd.pop_front());
        if (hreadyout === 1'b1)
            rdPend <= hsel && htrans[1] && !hwrite;
        since <= (|convDone) ? 0 : since + 1;
        for (int u = 0; u < 3; u++)
            if (convStart[u] !== 1'b0)
            begin
                lastGap <= since;
                chk("channel", {u[1:0], convChannel[u]},
                    expCh.size() ? expCh.pop_front() : 6'h3f);
            end
    end
    initial
    begin
        int u, ch, l, g, ge, sl;
        logic [31:0] w;
        void'($urandom(32'h2d12));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (u = 0; u < 3; u++)
        begin
            rd(ra(u, 8'h00), 32'h0);
            rd(ra(u, 8'h08), 32'h80);
        end
        rd(ra(3, 8'h00), 32'h0);
        w = {$urandom} & 32'hffff_ff77;
        u = $urandom % 3;
        xfer(ra(u, 8'h00), 1'b1, w);
        rd(ra(u, 8'h00), w);
        rd(ra((u + 1) % 3, 8'h00), 32'h0);
        xfer(ra(u, 8'h2c), 1'b1, w);
        rd(ra(u, 8'h2c), 32'h0);
        $display("test registers done");
        for (int tp = 0; tp < 3; tp++)
        begin
            // distinct units, so no stale dma word from an earlier pass
            u = (u + 1) % 3;
            ch = $urandom % 16;
            xfer(ra(u, 8'h04), 1'b1, ch);
            xfer(ra(u, 8'h28), 1'b1, 32'h2);
            // dma enable set together with unit enable in passes 0 and 1; pass 2 runs without dma
            xfer(ra(u, 8'h00), 1'b1, tp == 2 ? 32'h80 : 32'h0002_0080 | (tp << 16));
            expCh.push_back({u[1:0], ch[3:0]});
            xfer(ra(u, 8'h20), 1'b1, 32'h1);
            waitFor(400, 1);
            chk("irq", irq[u], tp != 2);
            w = tp ? {16'h0, {3{ch[3:0]}}, ch[3:0]} : {12'h0, ch[3:0], {3{ch[3:0]}}, 4'h0};
            rd(ra(u, 8'h2c), tp == 2 ? 32'h0 : w);
            rd(ra(u, 8'h24), tp == 2 ? 32'h1 : 32'h2);
            rd(ra(u, 8'h24), 32'h0);
            chk("irq clear", irq[u], 1'b0);
        end
        $display("test single done");
        for (int rep = 0; rep < 3; rep++)
        begin
            u = $urandom % 3;
            sl = $urandom;
            // at least two conversions, so an inner gap is always measured
            l = rep == 0 ? 7 : 1 + $urandom % 7;
            g = 1 + $urandom % 15;
            ge = rep == 1 ? 0 : $urandom % 2;
            xfer(ra(u, 8'h18), 1'b1, sl);
            xfer(ra(u, 8'h08), 1'b1, 32'h0180);
            for (int k = 0; k <= l; k++)
                expCh.push_back({u[1:0], sl[4*k+:4]});
            w = {g[7:0], 6'h0, 2'b10, 3'h0, ge[0], 1'b0, l[2:0], 8'hb0};
            xfer(ra(u, 8'h00), 1'b1, w);
            xfer(ra(u, 8'h20), 1'b1, 32'h1);
            waitFor(900, 1);
            // divider 1 makes one converter period two clocks
            chk("gap", 32'(ge ? lastGap == 2 * g + 1 : lastGap == 0), 32'h1);
            ch = sl[4*l+:4];
            rd(ra(u, 8'h2c), {12'h0, ch[3:0], {3{ch[3:0]}}, 4'h0});
            rd(ra(u, 8'h24), 32'h2);
        end
        $display("test burst done");
        u = $urandom % 3;
        ch = $urandom % 16;
        xfer(ra(u, 8'h04), 1'b1, ch);
        for (int s = 0; s < 9; s++)
        begin
            xfer(ra(u, 8'h00), 1'b1, s == 8 ? 32'h98 : 32'h88 | s);
            trig <= s < 6 ? ~(6'h1 << s) : 6'h3f;
            @(posedge clk);
            trig <= 6'h0;
            waitFor(400, 1);
            if (s >= 6)
                continue;
            expCh.push_back({u[1:0], ch[3:0]});
            trig <= 6'h1 << s;
            @(posedge clk);
            trig <= 6'h0;
            waitFor(400, 1);
        end
        $display("test triggers done");
        chk("leftover", expCh.size(), 32'h0);
        tally_and_finish();
    end
endmodule

// ==== hw/acs_top.sv ====
// three-unit conversion sequencer with its bus slave
// Functional notes
// - three identical independent units, own registers
// - unit banks at separate bases, 0x100 apart
// - sixteen selectable channel codes per unit
// - mode register is a full 32-bit word
// - mode bits 5:4 single, continuous or burst
// - enable bit 7 gates the converter, resets 0
// - burst length 0..7 gives 1..8 conversions
// - burst channels come from eight burst slots
// - bursts start at slot one, ascending order
// - gap enable bit 12 inserts wait before each later burst start
// - wait equals gap count times converter period
// - bit 3 gates hardware trigger sources
// - continuous mode ignores hardware triggers
// - source field selects pin, timers, pulse generators
// - dma enable bit 17 gates dma result updates
// - dma request per conversion/burst, irq on done
// - bit 16 chooses channel tag position
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps

module acs_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // register access
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] regOff,
    input wire logic [31:0] wrData,
    output logic [31:0] rdData,
    // trigger sources
    input wire logic [5:0] trigVec,
    // converter core
    output logic convStart,
    output logic [3:0] convChannel,
    input wire logic convDone,
    input wire logic [11:0] convResult,
    // dma and interrupt
    output logic dmaReq,
    input wire logic dmaDone,
    output logic irq
);
    typedef struct packed {
        logic [31:0] mode;
        logic [3:0] chanSel;
        logic [31:0] ctlOne;
        logic [2:0][31:0] trgChan;
        logic [31:0] burstSel;
        logic [31:0] compare;
        logic [31:0] dmaWord;
        logic [1:0] status;
        logic [1:0] mask;
        logic running;
        acs_pkg::acs_state_e state;
        logic [2:0] slot;
        logic [15:0] waitCnt;
        logic convStart;
        logic [3:0] convChan;
        logic dmaReq;
        logic irq;
    } acs_unit_s;

    acs_unit_s unit_reg;
    acs_unit_s unit_next;

    logic unitOn;
    logic [1:0] modeSel;
    logic isBurst;
    logic [2:0] burstLen;
    logic gapOn;
    logic dmaOn;
    logic tagLow;
    logic [7:0] gapCount;
    logic [2:0] trigSrc;
    logic [7:0] trigPad;
    logic hwTrig;
    logic swStart;
    logic swStop;
    logic [2:0] nextSlot;
    logic [7:0] divPlus;
    logic [15:0] gapCycles;

    assign unitOn = unit_reg.mode[acs_pkg::ACS_UNIT_EN_BIT];
    assign modeSel = unit_reg.mode[acs_pkg::ACS_MODE_LSB +: 2];
    assign isBurst = (modeSel == acs_pkg::ACS_MODE_BURST);
    assign burstLen = unit_reg.mode[acs_pkg::ACS_BURST_LEN_LSB +: 3];
    assign gapOn = unit_reg.mode[acs_pkg::ACS_GAP_EN_BIT];
    assign dmaOn = unit_reg.mode[acs_pkg::ACS_DMA_EN_BIT];
    assign tagLow = unit_reg.mode[acs_pkg::ACS_TAG_POS_BIT];
    assign gapCount = unit_reg.mode[acs_pkg::ACS_GAP_COUNT_LSB +: 8];
    assign trigSrc = unit_reg.mode[acs_pkg::ACS_TRIG_SRC_LSB +: 3];
    assign trigPad = {2'h0, trigVec};
    assign hwTrig = unit_reg.mode[acs_pkg::ACS_HW_TRIG_EN_BIT]
        && (modeSel != acs_pkg::ACS_MODE_CONT)
        && (trigSrc < acs_pkg::ACS_NUM_TRIG_SRC) && trigPad[trigSrc];
    assign swStart = wrEn && (regOff == acs_pkg::ACS_OFF_CONV_START)
        && wrData[acs_pkg::ACS_START_BIT];
    assign swStop = wrEn && (regOff == acs_pkg::ACS_OFF_CONV_START)
        && wrData[acs_pkg::ACS_STOP_BIT];
    assign nextSlot = unit_reg.slot + 3'h1;
    // converter period is divider plus one system clocks
    assign divPlus = {1'b0, unit_reg.ctlOne[acs_pkg::ACS_CLK_DIV_LSB +: 7]} + 8'h01;
    assign gapCycles = {8'h00, gapCount} * {8'h00, divPlus};

    // register read mux
    always_comb
    begin
        rdData = 32'h0000_0000;
        case (regOff)
            acs_pkg::ACS_OFF_CONV_MODE: rdData = unit_reg.mode;
            acs_pkg::ACS_OFF_CHANNEL_SELECT: rdData = {28'h0000000, unit_reg.chanSel};
            acs_pkg::ACS_OFF_CONV_CONTROL_ONE: rdData = unit_reg.ctlOne;
            acs_pkg::ACS_OFF_TRIGGER_CHAN_ZERO: rdData = unit_reg.trgChan[0];
            acs_pkg::ACS_OFF_TRIGGER_CHAN_ONE: rdData = unit_reg.trgChan[1];
            acs_pkg::ACS_OFF_TRIGGER_CHAN_TWO: rdData = unit_reg.trgChan[2];
            acs_pkg::ACS_OFF_BURST_CHAN_SELECT: rdData = unit_reg.burstSel;
            acs_pkg::ACS_OFF_CONV_START:
                rdData = {31'h00000000, unit_reg.state != acs_pkg::ACS_IDLE};
            acs_pkg::ACS_OFF_CONV_STATUS: rdData = {30'h00000000, unit_reg.status};
            acs_pkg::ACS_OFF_IRQ_ENABLE: rdData = {30'h00000000, unit_reg.mask};
            acs_pkg::ACS_OFF_DMA_RESULT: rdData = unit_reg.dmaWord;
            acs_pkg::ACS_OFF_CHAN_COMPARE: rdData = unit_reg.compare;
            default: rdData = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        logic finish;
        logic [31:0] word;
        finish = 1'b0;
        word = 32'h0000_0000;
        unit_next = unit_reg;
        unit_next.convStart = 1'b0;
        // status clear on read; later sets override it
        if (rdEn && (regOff == acs_pkg::ACS_OFF_CONV_STATUS))
        begin
            unit_next.status = 2'h0;
        end
        if (wrEn)
        begin
            case (regOff)
                acs_pkg::ACS_OFF_CONV_MODE: unit_next.mode = wrData;
                acs_pkg::ACS_OFF_CHANNEL_SELECT: unit_next.chanSel = wrData[3:0];
                acs_pkg::ACS_OFF_CONV_CONTROL_ONE: unit_next.ctlOne = wrData;
                acs_pkg::ACS_OFF_TRIGGER_CHAN_ZERO: unit_next.trgChan[0] = wrData;
                acs_pkg::ACS_OFF_TRIGGER_CHAN_ONE: unit_next.trgChan[1] = wrData;
                acs_pkg::ACS_OFF_TRIGGER_CHAN_TWO: unit_next.trgChan[2] = wrData;
                acs_pkg::ACS_OFF_BURST_CHAN_SELECT: unit_next.burstSel = wrData;
                acs_pkg::ACS_OFF_IRQ_ENABLE: unit_next.mask = wrData[1:0];
                acs_pkg::ACS_OFF_CHAN_COMPARE: unit_next.compare = wrData;
                default: unit_next.compare = unit_reg.compare;
            endcase
        end
        if (swStop)
        begin
            unit_next.running = 1'b0;
        end
        word[acs_pkg::ACS_RES_LSB +: 12] = convResult;
        if (tagLow)
        begin
            word[acs_pkg::ACS_TAG_LO_LSB +: 4] = unit_reg.convChan;
        end
        else
        begin
            word[acs_pkg::ACS_TAG_HI_LSB +: 4] = unit_reg.convChan;
        end
        case (unit_reg.state)
            acs_pkg::ACS_IDLE:
            begin
                // reserved mode code runs as single
                if (unitOn && (swStart || hwTrig))
                begin
                    unit_next.slot = 3'h0;
                    // every burst opens at slot one
                    unit_next.convChan = isBurst ? unit_reg.burstSel[3:0] : unit_reg.chanSel;
                    unit_next.convStart = 1'b1;
                    unit_next.running = (modeSel == acs_pkg::ACS_MODE_CONT) && !swStop;
                    unit_next.state = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV:
            begin
                if (convDone)
                begin
                    // result word only with dma on
                    if (dmaOn)
                    begin
                        unit_next.dmaWord = word;
                    end
                    // burst stops after length plus one
                    if (isBurst && (unit_reg.slot < burstLen))
                    begin
                        unit_next.slot = nextSlot;
                        // channel from the next burst slot
                        unit_next.convChan = unit_reg.burstSel[4 * nextSlot +: 4];
                        // optional gap before the next start
                        if (gapOn)
                        begin
                            unit_next.waitCnt = gapCycles;
                            unit_next.state = acs_pkg::ACS_GAP;
                        end
                        else
                        begin
                            unit_next.convStart = 1'b1;
                        end
                    end
                    // request once per conversion or burst
                    else if (dmaOn)
                    begin
                        unit_next.dmaReq = 1'b1;
                        unit_next.state = acs_pkg::ACS_DMA;
                    end
                    else
                    begin
                        unit_next.status[acs_pkg::ACS_ST_EOC_BIT] = 1'b1;
                        finish = 1'b1;
                    end
                end
            end
            acs_pkg::ACS_GAP:
            begin
                if (unit_reg.waitCnt == 16'h0000)
                begin
                    unit_next.convStart = 1'b1;
                    unit_next.state = acs_pkg::ACS_CONV;
                end
                else
                begin
                    unit_next.waitCnt = unit_reg.waitCnt - 16'h0001;
                end
            end
            acs_pkg::ACS_DMA:
            begin
                // interrupt event only on dma done
                if (dmaDone)
                begin
                    unit_next.dmaReq = 1'b0;
                    unit_next.status[acs_pkg::ACS_ST_DMA_BIT] = 1'b1;
                    finish = 1'b1;
                end
            end
            default: unit_next.state = acs_pkg::ACS_IDLE;
        endcase
        // continuous mode restarts until stopped
        if (finish)
        begin
            if (unit_next.running)
            begin
                unit_next.convChan = unit_reg.chanSel;
                unit_next.convStart = 1'b1;
                unit_next.state = acs_pkg::ACS_CONV;
            end
            else
            begin
                unit_next.state = acs_pkg::ACS_IDLE;
            end
        end
        // disabled unit drops everything in flight
        if (!unit_next.mode[acs_pkg::ACS_UNIT_EN_BIT])
        begin
            unit_next.state = acs_pkg::ACS_IDLE;
            unit_next.running = 1'b0;
            unit_next.dmaReq = 1'b0;
            unit_next.convStart = 1'b0;
        end
        unit_next.irq = |(unit_next.status & unit_next.mask);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            unit_reg <= '0;
            unit_reg.ctlOne <= acs_pkg::ACS_RST_CONV_CONTROL_ONE;
        end
        else if (ce)
        begin
            unit_reg <= unit_next;
        end
    end

    assign convStart = unit_reg.convStart;
    assign convChannel = unit_reg.convChan;
    assign dmaReq = unit_reg.dmaReq;
    assign irq = unit_reg.irq;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence burstStep;
        ce && (unit_reg.state == acs_pkg::ACS_CONV) && convDone && isBurst
            && (unit_reg.slot < burstLen);
    endsequence
    sequence idleKick;
        ce && (unit_reg.state == acs_pkg::ACS_IDLE) && unitOn && !swStart;
    endsequence

    disUnit_a: assert property (ce && !unit_next.mode[acs_pkg::ACS_UNIT_EN_BIT]
        |=> (unit_reg.state == acs_pkg::ACS_IDLE) && !dmaReq && !convStart)
        else $error("disabled unit still active");
    contNoTrig_a: assert property (idleKick and (modeSel == acs_pkg::ACS_MODE_CONT)
        |=> !convStart)
        else $error("continuous mode took a hardware trigger");
    rsvdSrc_a: assert property (idleKick and (trigSrc >= acs_pkg::ACS_NUM_TRIG_SRC)
        |=> !convStart)
        else $error("reserved trigger source started a conversion");
    dmaHold_a: assert property (ce && !dmaOn |=> $stable(unit_reg.dmaWord))
        else $error("dma result changed with dma off");
    noGap_a: assert property (burstStep and !gapOn |=> convStart)
        else $error("burst start delayed without gap");
    gapLoad_a: assert property (burstStep and gapOn
        |=> (unit_reg.state == acs_pkg::ACS_GAP) && (unit_reg.waitCnt == $past(gapCycles))
            && !convStart)
        else $error("gap count not loaded");
    burstFirst_a: assert property (ce && (unit_reg.state == acs_pkg::ACS_IDLE) && unitOn
        && isBurst && swStart |=> convStart && (convChannel == $past(unit_reg.burstSel[3:0])))
        else $error("burst did not open at slot one");
    burstChan_a: assert property (burstStep and !gapOn
        |=> convChannel == $past(unit_reg.burstSel[4 * nextSlot +: 4]))
        else $error("burst channel not from slot");
    slotBound_a: assert property (unit_reg.slot <= burstLen || !isBurst
        || unit_reg.state == acs_pkg::ACS_IDLE)
        else $error("burst slot past length");
    dmaIrq_a: assert property (ce && dmaOn && (unit_reg.state == acs_pkg::ACS_CONV)
        && convDone |=> !$rose(unit_reg.status[acs_pkg::ACS_ST_EOC_BIT]))
        else $error("end of conversion flagged with dma on");
endmodule

module acs_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // trigger sources, shared by all units
    input wire logic extTrig,
    input wire logic [2:0] timerTrig,
    input wire logic [1:0] pulseGenTrig,
    // converter cores
    output logic [2:0] convStart,
    output logic [2:0][3:0] convChannel,
    input wire logic [2:0] convDone,
    input wire logic [2:0][11:0] convResult,
    // dma and interrupts
    output logic [2:0] dmaReq,
    input wire logic [2:0] dmaDone,
    output logic [2:0] irq
);
    typedef struct packed {
        logic wrPend;
        logic rdPend;
        logic hit;
        logic [1:0] unit;
        logic [7:0] off;
        logic readyOut;
        logic [31:0] rdata;
    } acs_bus_s;

    acs_bus_s bus_reg;
    acs_bus_s bus_next;
    logic [2:0][31:0] unitRd;
    logic [2:0] unitWr;
    logic [2:0] unitRdEn;
    logic [5:0] trigVec;

    // source order: pin, timers, pulse generators
    assign trigVec = {pulseGenTrig, timerTrig, extTrig};

    // hsize ignored: only whole words are supported
    always_comb
    begin
        logic take;
        logic [31:0] unitBase;
        take = hsel && hready && htrans[1];
        unitBase = acs_pkg::ACS_BASE_ADDR;
        bus_next = bus_reg;
        bus_next.wrPend = 1'b0;
        if (bus_reg.rdPend)
        begin
            bus_next.rdPend = 1'b0;
            bus_next.readyOut = 1'b1;
            bus_next.rdata = bus_reg.hit ? unitRd[bus_reg.unit] : 32'h0000_0000;
        end
        if (take)
        begin
            bus_next.wrPend = hwrite;
            bus_next.rdPend = !hwrite;
            // reads add one wait so a preceding write is visible
            bus_next.readyOut = hwrite;
            bus_next.off = haddr[7:0];
            bus_next.hit = 1'b0;
            bus_next.unit = 2'h0;
            // one bank per unit, stride apart
            for (int i = 0; i < acs_pkg::ACS_NUM_UNITS; i++)
            begin
                if (haddr[31:8] == unitBase[31:8])
                begin
                    bus_next.hit = 1'b1;
                    bus_next.unit = 2'(i);
                end
                unitBase = unitBase + acs_pkg::ACS_UNIT_STRIDE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_reg <= '0;
            bus_reg.readyOut <= 1'b1;
        end
        else if (ce)
        begin
            bus_reg <= bus_next;
        end
    end

    assign hreadyout = bus_reg.readyOut;
    assign hresp = 1'b0;
    assign hrdata = bus_reg.rdata;

    for (genvar u = 0; u < acs_pkg::ACS_NUM_UNITS; u++)
    begin : g_unit
        assign unitWr[u] = bus_reg.wrPend && bus_reg.hit && (bus_reg.unit == 2'(u));
        assign unitRdEn[u] = bus_reg.rdPend && bus_reg.hit && (bus_reg.unit == 2'(u));
        acs_unit u_unit (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .wrEn(unitWr[u]),
            .rdEn(unitRdEn[u]),
            .regOff(bus_reg.off),
            .wrData(hwdata),
            .rdData(unitRd[u]),
            .trigVec(trigVec),
            .convStart(convStart[u]),
            .convChannel(convChannel[u]),
            .convDone(convDone[u]),
            .convResult(convResult[u]),
            .dmaReq(dmaReq[u]),
            .dmaDone(dmaDone[u]),
            .irq(irq[u])
        );
    end
endmodule

// ==== inc/acs_pkg.sv ====
// constants and types shared by the conversion sequencer
package acs_pkg;
    // bus map
    localparam int unsigned ACS_NUM_UNITS = 3;
    localparam logic [31:0] ACS_BASE_ADDR = 32'h4000_b000;
    localparam logic [31:0] ACS_UNIT_STRIDE = 32'h0000_0100;
    // register offsets inside one unit
    localparam logic [7:0] ACS_OFF_CONV_MODE = 8'h00;
    localparam logic [7:0] ACS_OFF_CHANNEL_SELECT = 8'h04;
    localparam logic [7:0] ACS_OFF_CONV_CONTROL_ONE = 8'h08;
    localparam logic [7:0] ACS_OFF_TRIGGER_CHAN_ZERO = 8'h0c;
    localparam logic [7:0] ACS_OFF_TRIGGER_CHAN_ONE = 8'h10;
    localparam logic [7:0] ACS_OFF_TRIGGER_CHAN_TWO = 8'h14;
    localparam logic [7:0] ACS_OFF_BURST_CHAN_SELECT = 8'h18;
    localparam logic [7:0] ACS_OFF_CONV_START = 8'h20;
    localparam logic [7:0] ACS_OFF_CONV_STATUS = 8'h24;
    localparam logic [7:0] ACS_OFF_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] ACS_OFF_DMA_RESULT = 8'h2c;
    localparam logic [7:0] ACS_OFF_CHAN_COMPARE = 8'h70;
    // reset values
    localparam logic [31:0] ACS_RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] ACS_RST_CONV_CONTROL_ONE = 32'h0000_0080;
    // conv_mode fields
    localparam int unsigned ACS_TRIG_SRC_LSB = 0;
    localparam int unsigned ACS_HW_TRIG_EN_BIT = 3;
    localparam int unsigned ACS_MODE_LSB = 4;
    localparam int unsigned ACS_UNIT_EN_BIT = 7;
    localparam int unsigned ACS_BURST_LEN_LSB = 8;
    localparam int unsigned ACS_GAP_EN_BIT = 12;
    localparam int unsigned ACS_TAG_POS_BIT = 16;
    localparam int unsigned ACS_DMA_EN_BIT = 17;
    localparam int unsigned ACS_GAP_COUNT_LSB = 24;
    // conversion modes and trigger sources
    localparam logic [1:0] ACS_MODE_SINGLE = 2'h0;
    localparam logic [1:0] ACS_MODE_CONT = 2'h1;
    localparam logic [1:0] ACS_MODE_BURST = 2'h3;
    localparam logic [2:0] ACS_NUM_TRIG_SRC = 3'h6;
    // conv_control_one clock divider field
    localparam int unsigned ACS_CLK_DIV_LSB = 8;
    // conv_start, conv_status and dma word fields
    localparam int unsigned ACS_START_BIT = 0;
    localparam int unsigned ACS_STOP_BIT = 4;
    localparam int unsigned ACS_ST_EOC_BIT = 0;
    localparam int unsigned ACS_ST_DMA_BIT = 1;
    localparam int unsigned ACS_RES_LSB = 4;
    localparam int unsigned ACS_TAG_HI_LSB = 16;
    localparam int unsigned ACS_TAG_LO_LSB = 0;

    typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_GAP, ACS_DMA} acs_state_e;
endpackage
